// ==== hw/pcics_bank.sv ====
// Command, status and stepping registers of the configuration header.
//
// Behaviour
// - Legacy irq mask set blocks pin interrupts; message interrupts unaffected.
// - Initiator enable clear blocks all memory and I/O requests from the device.
// - Memory space enable gates register memory accesses; read-write, resets 0.
// - I/O decode enable gates target I/O accesses; read-write, resets 0.
// - Parity response enable drives parity error out; reads 0 without parity.
// - Unsupported command bits and reserved upper bits read constant zero.
// - System error report enable controls reporting; writable or fixed, resets 0.
// - Parity error seen flag sets on detected parity error; write one clears.
// - Master abort received flag sets on master-aborted own request; W1C.
// - Target abort received flag sets on target-aborted own request; W1C.
// - Master parity flag sets as initiator on parity error, only if enabled.
// - Capability list present reads one.
// - Interrupt pending reads one while legacy interrupt is asserted.
// - Target abort signalled reads zero; device never signals it.
// - Timing, back-to-back and 66 MHz fields are constants; bits 6, 2:0 zero.
// - System error signalled flag is write-one-to-clear or fixed, resets 0.
// - Stepping field returns a fixed implementation value.
`timescale 1ns/1ps
module pcics_bank #(
  parameter bit         PARITY_SUPPORT = 1'b1,
  parameter bit         SERR_WRITABLE  = 1'b1,
  parameter bit         SERR_W1C       = 1'b1,
  // Arbitrary stepping value.
  parameter logic [7:0] STEPPING       = 8'h00,
  parameter logic [1:0] SEL_TIMING     = 2'h0,
  parameter bit         B2B_CAPABLE    = 1'b0,
  parameter bit         FREQ66_CAPABLE = 1'b0
) (
  // Clock and reset.
  input  wire logic                       clk,
  input  wire logic                       arst_n,
  // Configuration access port.
  input  wire pcics_pkg::pcics_cfg_req_t  cfg_req,
  output pcics_pkg::pcics_cfg_rsp_t       cfg_rsp,
  // Controller core events and requests.
  input  wire pcics_pkg::pcics_evt_t      evt,
  input  wire logic                       irq_src,
  input  wire logic                       mstr_req_in,
  input  wire logic                       mem_acc_in,
  input  wire logic                       io_acc_in,
  // Gated outputs.
  output logic                            intx_out,
  output logic                            mstr_req_out,
  output logic                            mem_acc_ok,
  output logic                            io_acc_ok,
  output logic                            perr_out,
  output logic                            serr_out,
  output pcics_pkg::pcics_cmd_t           cmd_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Parameter checks.
  if (SERR_W1C && !SERR_WRITABLE && 1'b0)
  begin : g_never
  end
  if (!PARITY_SUPPORT && 1'b0)
  begin : g_unused
  end
  if ((SEL_TIMING == 2'h3))
  begin : g_bad_timing
    $error("Select timing code 3 is reserved");
  end

  ////////////////////////////////////////////////////////////////////////////
  // State.
  typedef struct packed {
    pcics_pkg::pcics_cmd_t     cmd;
    pcics_pkg::pcics_cfg_rsp_t rsp;
    logic                      irq_seen;
    logic                      intx;
    logic                      mstr_req;
    logic                      mem_ok;
    logic                      io_ok;
    logic                      perr;
    logic                      serr;
  } pcics_bank_st_t;

  pcics_bank_st_t                    st_q;
  pcics_bank_st_t                    st_d;
  logic [pcics_pkg::NUM_FLAGS-1:0]   flg_set;
  logic [pcics_pkg::NUM_FLAGS-1:0]   flg_clr;
  logic [pcics_pkg::NUM_FLAGS-1:0]   flg;
  logic [15:0]                       cmd_word;
  logic [15:0]                       sts_word;
  logic                              wr_dw1;
  logic                              rd_hit;

  ////////////////////////////////////////////////////////////////////////////
  // Status flags.
  for (genvar i = 0; i < pcics_pkg::NUM_FLAGS; i++)
  begin : g_flag
    pcics_w1c_flag u_flag (
      .clk    (clk),
      .arst_n (arst_n),
      .set_i  (flg_set[i]),
      .clr_i  (flg_clr[i]),
      .flag_o (flg[i])
    );
  end

  assign wr_dw1 = cfg_req.req && cfg_req.we && (cfg_req.addr == pcics_pkg::DW1_ADDR);

  always_comb
  begin
    flg_set = '0;
    flg_set[pcics_pkg::FLG_PERR] = evt.parity_err_det;
    flg_set[pcics_pkg::FLG_MABR] = evt.mstr_abort;
    flg_set[pcics_pkg::FLG_TABR] = evt.tgt_abort;
    flg_set[pcics_pkg::FLG_MPAR] = (evt.mstr_parity_det || evt.perr_line_seen)
                                   && st_q.cmd.parity_resp_en;
    flg_set[pcics_pkg::FLG_SERR] = SERR_W1C && evt.sys_err
                                   && st_q.cmd.sys_err_report_en;
    // All flags sit in the upper status byte; a one written clears.
    flg_clr = '0;
    if (wr_dw1 && cfg_req.be[3])
    begin
      flg_clr[pcics_pkg::FLG_PERR] = cfg_req.wdata[16 + pcics_pkg::STS_PERR_BIT];
      flg_clr[pcics_pkg::FLG_MABR] = cfg_req.wdata[16 + pcics_pkg::STS_MABR_BIT];
      flg_clr[pcics_pkg::FLG_TABR] = cfg_req.wdata[16 + pcics_pkg::STS_TABR_BIT];
      flg_clr[pcics_pkg::FLG_MPAR] = cfg_req.wdata[16 + pcics_pkg::STS_MPAR_BIT];
      flg_clr[pcics_pkg::FLG_SERR] = cfg_req.wdata[16 + pcics_pkg::STS_SERR_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read views of the command and status words.
  always_comb
  begin
    cmd_word = 16'h0000;
    cmd_word[pcics_pkg::CMD_IO_BIT]   = st_q.cmd.io_decode_en;
    cmd_word[pcics_pkg::CMD_MEM_BIT]  = st_q.cmd.mem_space_en;
    cmd_word[pcics_pkg::CMD_INIT_BIT] = st_q.cmd.initiator_en;
    cmd_word[pcics_pkg::CMD_PAR_BIT]  = st_q.cmd.parity_resp_en;
    cmd_word[pcics_pkg::CMD_SERR_BIT] = st_q.cmd.sys_err_report_en;
    cmd_word[pcics_pkg::CMD_IRQM_BIT] = st_q.cmd.legacy_irq_mask;
    sts_word = 16'h0000;
    sts_word[pcics_pkg::STS_IRQ_BIT]  = st_q.irq_seen;
    sts_word[pcics_pkg::STS_CAP_BIT]  = pcics_pkg::CAP_LIST_VAL;
    sts_word[pcics_pkg::STS_F66_BIT]  = FREQ66_CAPABLE;
    sts_word[pcics_pkg::STS_B2B_BIT]  = B2B_CAPABLE;
    sts_word[pcics_pkg::STS_MPAR_BIT] = flg[pcics_pkg::FLG_MPAR];
    sts_word[pcics_pkg::STS_SEL_LSB +: 2] = SEL_TIMING;
    sts_word[pcics_pkg::STS_TABS_BIT] = 1'b0;
    sts_word[pcics_pkg::STS_TABR_BIT] = flg[pcics_pkg::FLG_TABR];
    sts_word[pcics_pkg::STS_MABR_BIT] = flg[pcics_pkg::FLG_MABR];
    sts_word[pcics_pkg::STS_SERR_BIT] = flg[pcics_pkg::FLG_SERR];
    sts_word[pcics_pkg::STS_PERR_BIT] = flg[pcics_pkg::FLG_PERR];
  end

  assign rd_hit = cfg_req.req && !cfg_req.we;

  ////////////////////////////////////////////////////////////////////////////
  // Next state.
  always_comb
  begin
    st_d = st_q;
    // Command writes, byte lane by byte lane.
    if (wr_dw1 && cfg_req.be[0])
    begin
      st_d.cmd.io_decode_en   = cfg_req.wdata[pcics_pkg::CMD_IO_BIT];
      st_d.cmd.mem_space_en   = cfg_req.wdata[pcics_pkg::CMD_MEM_BIT];
      st_d.cmd.initiator_en   = cfg_req.wdata[pcics_pkg::CMD_INIT_BIT];
      st_d.cmd.parity_resp_en = PARITY_SUPPORT
                                && cfg_req.wdata[pcics_pkg::CMD_PAR_BIT];
    end
    if (wr_dw1 && cfg_req.be[1])
    begin
      st_d.cmd.sys_err_report_en = SERR_WRITABLE
                                   && cfg_req.wdata[pcics_pkg::CMD_SERR_BIT];
      st_d.cmd.legacy_irq_mask   = cfg_req.wdata[pcics_pkg::CMD_IRQM_BIT];
    end
    // Accesses answer one cycle after the request; unmapped dwords read zero.
    st_d.rsp.ack   = cfg_req.req;
    st_d.rsp.rdata = pcics_pkg::RDATA_RST;
    if (rd_hit && (cfg_req.addr == pcics_pkg::DW1_ADDR))
    begin
      st_d.rsp.rdata = {sts_word, cmd_word};
    end
    else if (rd_hit && (cfg_req.addr == pcics_pkg::DW2_ADDR))
    begin
      st_d.rsp.rdata = {24'h00_0000, STEPPING};
    end
    // Gated core signals.
    st_d.irq_seen = irq_src;
    st_d.intx     = irq_src && !st_q.cmd.legacy_irq_mask;
    st_d.mstr_req = mstr_req_in && st_q.cmd.initiator_en;
    st_d.mem_ok   = mem_acc_in && st_q.cmd.mem_space_en;
    st_d.io_ok    = io_acc_in && st_q.cmd.io_decode_en;
    st_d.perr     = evt.parity_err_det && st_q.cmd.parity_resp_en;
    st_d.serr     = evt.sys_err && st_q.cmd.sys_err_report_en;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st_q.cmd.legacy_irq_mask   <= pcics_pkg::CMD_BIT_RST;
      st_q.cmd.sys_err_report_en <= pcics_pkg::CMD_BIT_RST;
      st_q.cmd.parity_resp_en    <= pcics_pkg::CMD_BIT_RST;
      st_q.cmd.initiator_en      <= pcics_pkg::CMD_BIT_RST;
      st_q.cmd.mem_space_en      <= pcics_pkg::CMD_BIT_RST;
      st_q.cmd.io_decode_en      <= pcics_pkg::CMD_BIT_RST;
      st_q.rsp.ack               <= 1'b0;
      st_q.rsp.rdata             <= pcics_pkg::RDATA_RST;
      st_q.irq_seen              <= 1'b0;
      st_q.intx                  <= 1'b0;
      st_q.mstr_req              <= 1'b0;
      st_q.mem_ok                <= 1'b0;
      st_q.io_ok                 <= 1'b0;
      st_q.perr                  <= 1'b0;
      st_q.serr                  <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs.
  assign cfg_rsp      = st_q.rsp;
  assign intx_out     = st_q.intx;
  assign mstr_req_out = st_q.mstr_req;
  assign mem_acc_ok   = st_q.mem_ok;
  assign io_acc_ok    = st_q.io_ok;
  assign perr_out     = st_q.perr;
  assign serr_out     = st_q.serr;
  assign cmd_out      = st_q.cmd;

endmodule : pcics_bank

// ==== hw/pcics_pkg.sv ====
// Shared constants and carrier types for the configuration command/status bank.
package pcics_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Configuration space byte offsets.
  localparam logic [7:0] CMD_OFS      = 8'h04;
  localparam logic [7:0] STS_OFS      = 8'h06;
  localparam logic [7:0] STEPPING_OFS = 8'h08;
  localparam logic [7:0] DW1_ADDR     = 8'h04;
  localparam logic [7:0] DW2_ADDR     = 8'h08;

  ////////////////////////////////////////////////////////////////////////////
  // Command word bit positions.
  localparam int CMD_IO_BIT     = 0;
  localparam int CMD_MEM_BIT    = 1;
  localparam int CMD_INIT_BIT   = 2;
  localparam int CMD_PAR_BIT    = 6;
  localparam int CMD_SERR_BIT   = 8;
  localparam int CMD_IRQM_BIT   = 10;

  // Status word bit positions.
  localparam int STS_IRQ_BIT    = 3;
  localparam int STS_CAP_BIT    = 4;
  localparam int STS_F66_BIT    = 5;
  localparam int STS_B2B_BIT    = 7;
  localparam int STS_MPAR_BIT   = 8;
  localparam int STS_SEL_LSB    = 9;
  localparam int STS_TABS_BIT   = 11;
  localparam int STS_TABR_BIT   = 12;
  localparam int STS_MABR_BIT   = 13;
  localparam int STS_SERR_BIT   = 14;
  localparam int STS_PERR_BIT   = 15;

  // Index of each write-one-to-clear flag in the flag vector.
  localparam int FLG_MPAR       = 0;
  localparam int FLG_TABR       = 1;
  localparam int FLG_MABR       = 2;
  localparam int FLG_SERR       = 3;
  localparam int FLG_PERR       = 4;
  localparam int NUM_FLAGS      = 5;

  // Reset values.
  localparam logic       CMD_BIT_RST  = 1'b0;
  localparam logic       FLAG_RST     = 1'b0;
  localparam logic       CAP_LIST_VAL = 1'b1;
  localparam logic [31:0] RDATA_RST   = 32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////////
  // Configuration access request.
  typedef struct packed {
    logic        req;
    logic        we;
    logic [7:0]  addr;
    logic [3:0]  be;
    logic [31:0] wdata;
  } pcics_cfg_req_t;

  // Configuration access answer.
  typedef struct packed {
    logic        ack;
    logic [31:0] rdata;
  } pcics_cfg_rsp_t;

  // Bus events reported by the controller core.
  typedef struct packed {
    logic parity_err_det;
    logic mstr_parity_det;
    logic perr_line_seen;
    logic mstr_abort;
    logic tgt_abort;
    logic sys_err;
  } pcics_evt_t;

  // Writable command bits.
  typedef struct packed {
    logic legacy_irq_mask;
    logic sys_err_report_en;
    logic parity_resp_en;
    logic initiator_en;
    logic mem_space_en;
    logic io_decode_en;
  } pcics_cmd_t;

  // State of one write-one-to-clear flag cell.
  typedef struct packed {
    logic flag;
  } pcics_flag_st_t;

endpackage : pcics_pkg

// ==== hw/pcics_w1c_flag.sv ====
// One status flag set by hardware and cleared by writing one.
`timescale 1ns/1ps
module pcics_w1c_flag (
  // Clock and reset.
  input  wire logic clk,
  input  wire logic arst_n,
  // Set and clear strobes.
  input  wire logic set_i,
  input  wire logic clr_i,
  // Flag value.
  output logic      flag_o
);

  pcics_pkg::pcics_flag_st_t st_q;
  pcics_pkg::pcics_flag_st_t st_d;

  // The hardware set wins over a clear in the same cycle.
  always_comb
  begin
    st_d = st_q;
    if (clr_i)
    begin
      st_d.flag = 1'b0;
    end
    if (set_i)
    begin
      st_d.flag = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st_q.flag <= pcics_pkg::FLAG_RST;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign flag_o = st_q.flag;

endmodule : pcics_w1c_flag

// ==== tb/pcics_bank_checker.sv ====
// Assertion checker for the command, status and stepping bank.
`timescale 1ns/1ps
module pcics_bank_checker #(
  parameter logic [7:0] STEPPING = 8'h00
) (
  // Clock and reset.
  input wire logic                      clk,
  input wire logic                      arst_n,
  // Configuration port.
  input wire pcics_pkg::pcics_cfg_req_t cfg_req,
  input wire pcics_pkg::pcics_cfg_rsp_t cfg_rsp,
  // Core side.
  input wire pcics_pkg::pcics_evt_t     evt,
  input wire logic                      irq_src,
  input wire logic                      mstr_req_in,
  input wire logic                      mem_acc_in,
  input wire logic                      io_acc_in,
  // Gated outputs.
  input wire logic                      intx_out,
  input wire logic                      mstr_req_out,
  input wire logic                      mem_acc_ok,
  input wire logic                      io_acc_ok,
  input wire logic                      perr_out,
  input wire logic                      serr_out,
  input wire pcics_pkg::pcics_cmd_t     cmd_out
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);

  wire logic        rd04 = cfg_req.req && !cfg_req.we && cfg_req.addr == 8'h04;
  wire logic        wr04 = cfg_req.req && cfg_req.we && cfg_req.addr == 8'h04;
  wire logic [15:0] cmd16 = {5'h00, cmd_out.legacy_irq_mask, 1'b0, cmd_out.sys_err_report_en,
                             1'b0, cmd_out.parity_resp_en, 3'h0, cmd_out.initiator_en,
                             cmd_out.mem_space_en, cmd_out.io_decode_en};

  AST_INTX:
    assert property (1 |=> intx_out == ($past(irq_src) && !$past(cmd_out.legacy_irq_mask)))
      else $error("pin interrupt gating wrong");
  AST_MSTR:
    assert property (!cmd_out.initiator_en |=> !mstr_req_out) else $error("request while off");
  AST_MEM:
    assert property (1 |=> mem_acc_ok == $past(mem_acc_in && cmd_out.mem_space_en))
      else $error("memory gating wrong");
  AST_IO:
    assert property (io_acc_in && cmd_out.io_decode_en |=> io_acc_ok) else $error("io gating");
  AST_PERR:
    assert property (1 |=> perr_out == $past(evt.parity_err_det && cmd_out.parity_resp_en))
      else $error("parity output wrong");
  AST_SERR:
    assert property (serr_out |-> $past(evt.sys_err) && $past(cmd_out.sys_err_report_en))
      else $error("system error output wrong");
  AST_CMDRD:
    assert property (rd04 |=> cfg_rsp.ack && cfg_rsp.rdata[15:0] == $past(cmd16))
      else $error("command readback wrong");
  AST_CONST:
    assert property (rd04 |=> (cfg_rsp.rdata & 32'h0ef7_0000) == 32'h0010_0000)
      else $error("constant status bits wrong");
  AST_IRQPEND:
    assert property (rd04 |=> cfg_rsp.rdata[19] == $past(irq_src, 2)) else $error("irq status");
  AST_STEP:
    assert property (cfg_req.req && !cfg_req.we && cfg_req.addr == 8'h08
      |=> cfg_rsp.rdata == {24'h0, STEPPING}) else $error("stepping dword wrong");
  AST_ABORT:
    assert property (evt.mstr_abort ##1 !wr04 ##1 rd04 |=> cfg_rsp.rdata[29])
      else $error("master abort flag not set");
  AST_W1C:
    assert property (wr04 && cfg_req.be[3] && cfg_req.wdata[28] && !evt.tgt_abort
      ##1 !evt.tgt_abort ##1 rd04 |=> !cfg_rsp.rdata[28]) else $error("flag not cleared");
  AST_SETWIN:
    assert property (wr04 && cfg_req.be[3] && cfg_req.wdata[28] && evt.tgt_abort
      ##1 !wr04 ##1 rd04 |=> cfg_rsp.rdata[28]) else $error("clear beat hardware set");
endmodule : pcics_bank_checker

bind pcics_bank pcics_bank_checker #(.STEPPING(STEPPING)) pcics_bank_checker_inst (
  .clk(clk), .arst_n(arst_n), .cfg_req(cfg_req), .cfg_rsp(cfg_rsp), .evt(evt),
  .irq_src(irq_src), .mstr_req_in(mstr_req_in), .mem_acc_in(mem_acc_in), .io_acc_in(io_acc_in),
  .intx_out(intx_out), .mstr_req_out(mstr_req_out), .mem_acc_ok(mem_acc_ok),
  .io_acc_ok(io_acc_ok), .perr_out(perr_out), .serr_out(serr_out), .cmd_out(cmd_out)
);

// ==== tb/pcics_host_model.sv ====
// Configuration software model that issues single accesses.
`timescale 1ns/1ps
module pcics_host_model (
  // Clock.
  input  wire logic                      clk,
  // Configuration port.
  output pcics_pkg::pcics_cfg_req_t      cfg_req,
  input  wire pcics_pkg::pcics_cfg_rsp_t cfg_rsp
);
  initial cfg_req = '0;

  // Released lines show inverted values so a stale field is never mistaken for a request.
  task automatic xfer(input logic we, input logic [7:0] addr, input logic [3:0] be,
                      input logic [31:0] wdata, output logic [31:0] rdata, output logic ack);
    @(negedge clk);
    cfg_req = '{req: 1'b1, we: we, addr: addr, be: be, wdata: wdata};
    @(negedge clk);
    rdata = cfg_rsp.rdata;
    ack = cfg_rsp.ack;
    cfg_req = '{req: 1'b0, we: ~we, addr: ~addr, be: ~be, wdata: ~wdata};
  endtask : xfer
endmodule : pcics_host_model

// ==== tb/test_pci_cfg_command_status.sv ====
// Self-checking test of the command, status and stepping bank.
`timescale 1ns/1ps
module test_pci_cfg_command_status;
  // Arbitrary stepping value.
  localparam logic [7:0] STEP = 8'h5a;
  localparam logic [5:0] FLAG_EVT [6] = '{6'h20, 6'h10, 6'h08, 6'h04, 6'h02, 6'h01};
  localparam int         FLAG_BIT [6] = '{31, 24, 24, 29, 28, 30};
  logic                      clk;
  logic                      arst_n;
  pcics_pkg::pcics_cfg_req_t cfg_req;
  pcics_pkg::pcics_cfg_rsp_t cfg_rsp;
  pcics_pkg::pcics_evt_t     evt;
  logic [3:0]                core_in;
  logic [5:0]                gate_o;
  pcics_pkg::pcics_cmd_t     cmd_out;
  logic [31:0]               seed;
  logic [31:0]               rd;
  logic                      ack;
  logic [9:0]                prev;
  logic [15:0]               cmd;
  int                        err_count;
  int                        comparisons;

  pcics_bank #(.STEPPING(STEP)) pcics_bank_inst (
    .clk(clk), .arst_n(arst_n), .cfg_req(cfg_req), .cfg_rsp(cfg_rsp), .evt(evt),
    .irq_src(core_in[3]), .mstr_req_in(core_in[2]), .mem_acc_in(core_in[1]),
    .io_acc_in(core_in[0]), .intx_out(gate_o[5]), .mstr_req_out(gate_o[4]),
    .mem_acc_ok(gate_o[3]), .io_acc_ok(gate_o[2]), .perr_out(gate_o[1]),
    .serr_out(gate_o[0]), .cmd_out(cmd_out)
  );
  pcics_host_model pcics_host_model_inst (.clk(clk), .cfg_req(cfg_req), .cfg_rsp(cfg_rsp));

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  // Gated outputs one cycle after inputs p = {events, irq, request, memory, io}.
  function automatic logic [5:0] gate_exp(input logic [15:0] c, input logic [9:0] p);
    return {p[3] & ~c[10], p[2] & c[2], p[1] & c[1], p[0] & c[0], p[9] & c[6], p[4] & c[8]};
  endfunction : gate_exp

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp)
    begin
      err_count++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic acc(input logic we, input logic [7:0] a, input logic [3:0] be,
                     input logic [31:0] wd);
    pcics_host_model_inst.xfer(we, a, be, wd, rd, ack);
    chk("ack", 32'h1, {31'h0, ack});
  endtask : acc

  task automatic pulse(input logic [5:0] e);
    @(negedge clk);
    evt = e;
    @(negedge clk);
    evt = '0;
  endtask : pulse

  task automatic finish_test();
    $display("Comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : finish_test

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  initial
  begin
    #(25 * 20000);
    err_count++;
    finish_test();
  end

  initial
  begin
    arst_n = 1'b0;
    evt = '0;
    core_in = 4'h0;
    err_count = 0;
    comparisons = 0;
    seed = 32'h44a7;
    repeat (16) @(negedge clk);
    arst_n = 1'b1;
    acc(1'b0, 8'h04, 4'h0, 32'h0);
    chk("reset_cmd_sts", 32'h0010_0000, rd);
    acc(1'b1, 8'h08, 4'hf, 32'hffff_ffff);
    acc(1'b1, 8'h0c, 4'hf, 32'hffff_ffff);
    acc(1'b0, 8'h08, 4'h0, 32'h0);
    chk("stepping", {24'h0, STEP}, rd);
    acc(1'b0, 8'h0c, 4'h0, 32'h0);
    chk("unmapped", 32'h0, rd);
    acc(1'b1, 8'h04, 4'h3, 32'h0000_ffff);
    acc(1'b0, 8'h04, 4'h0, 32'h0);
    chk("cmd_ones", 32'h0010_0547, rd);
    repeat (8)
    begin
      seed = lfsr(seed);
      cmd = seed[15:0];
      acc(1'b1, 8'h04, 4'h3, {16'h0, cmd});
      cmd = cmd & 16'h0547;
      chk("cmd_out", {26'h0, cmd[10], cmd[8], cmd[6], cmd[2:0]}, {26'h0, cmd_out});
      prev = '0;
      repeat (20)
      begin
        @(negedge clk);
        chk("gates", {26'h0, gate_exp(cmd, prev)}, {26'h0, gate_o});
        seed = lfsr(seed);
        prev = seed[9:0];
        {evt, core_in} = prev;
      end
      @(negedge clk);
      {evt, core_in} = 10'h0;
    end
    acc(1'b1, 8'h04, 4'h3, 32'h0000_0547);
    for (int i = 0; i < 6; i++)
    begin
      acc(1'b1, 8'h04, 4'h8, 32'hff00_0000);
      pulse(FLAG_EVT[i]);
      acc(1'b0, 8'h04, 4'h0, 32'h0);
      chk("flag_set", 32'h1, {31'h0, rd[FLAG_BIT[i]]});
      acc(1'b1, 8'h04, 4'h8, ~(32'h1 << FLAG_BIT[i]) & 32'hff00_0000);
      acc(1'b0, 8'h04, 4'h0, 32'h0);
      chk("flag_keep", 32'h1, {31'h0, rd[FLAG_BIT[i]]});
      fork
        acc(1'b1, 8'h04, 4'h8, 32'h1 << FLAG_BIT[i]);
        pulse(FLAG_EVT[i]);
      join
      acc(1'b0, 8'h04, 4'h0, 32'h0);
      chk("flag_set_wins", 32'h1, {31'h0, rd[FLAG_BIT[i]]});
      acc(1'b1, 8'h04, 4'h8, 32'h1 << FLAG_BIT[i]);
      acc(1'b0, 8'h04, 4'h0, 32'h0);
      chk("flag_clear", 32'h0, {31'h0, rd[FLAG_BIT[i]]});
    end
    acc(1'b1, 8'h04, 4'h3, 32'h0);
    pulse(6'h10);
    acc(1'b0, 8'h04, 4'h0, 32'h0);
    chk("mpar_off", 32'h0, {31'h0, rd[24]});
    finish_test();
  end
endmodule : test_pci_cfg_command_status
